// file: design/pmf_pkg.sv
package pmf_pkg;
    // ****************************************
    // Flag positions and widths
    // ****************************************
    localparam int          FLAG_W        = 32;
    localparam int          ADDR_W        = 32;
    localparam int          SINGLE_STEP_B = 8;
    localparam int          INT_ENABLE_B  = 9;
    localparam int          IO_PRIVILEGE_FIELD_LO_B     = 12;
    localparam int          IO_PRIVILEGE_FIELD_HI_B     = 13;
    localparam int          V86_SELECT_B  = 17;
    localparam logic [31:0] FLAGS_RESET   = 32'h0000_0002;
    localparam logic [31:0] FLAGS_FIXED1  = 32'h0000_0002;
    // Writable flag mask: bits 0..21 minus fixed positions
    localparam logic [31:0] FLAGS_WMASK   = 32'h003F_7FD5;
    localparam logic [31:0] FLAGS_SYSMASK = 32'h0002_3300;
    // ****************************************
    // Linear address split for paging
    // ****************************************
    localparam int          DIR_IDX_LO    = 22;
    localparam int          TBL_IDX_LO    = 12;
    localparam int          IDX_W         = 10;
    localparam int          OFFS_W        = 12;
    localparam logic [31:0] PDBR_RESET    = 32'h0000_0000;
    localparam logic [31:0] PDBR_MASK     = 32'hFFFF_F000;
    // ****************************************
    // Modes and flag-writing instructions
    // ****************************************
    typedef enum logic [3:0] {
        PMF_REAL = 4'h1,
        PMF_PROT = 4'h2,
        PMF_V86  = 4'h4,
        PMF_MGMT = 4'h8
    } pmf_mode_t;
    typedef enum logic [2:0] {
        PMF_OP_NONE  = 3'h0,
        PMF_OP_CLI   = 3'h1,
        PMF_OP_STI   = 3'h2,
        PMF_OP_FLAGS_POP_INSTR  = 3'h3,
        PMF_OP_INTERRUPT_RETURN_INSTR  = 3'h4,
        PMF_OP_TASK  = 3'h5,
        PMF_OP_OTHER = 3'h6
    } pmf_op_t;
endpackage : pmf_pkg

// file: design/pmf_sync.sv
`timescale 1ns/10ps
module pmf_sync (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Level
    input  wire logic async_i,
    output logic      sync_o
);
    logic meta_reg;
    // Reset high: pin is active low, idle high
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            sync_o   <= 1'b1;
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule : pmf_sync

// file: design/pmf_xlate.sv
`timescale 1ns/10ps
module pmf_xlate
    import pmf_pkg::*;
(
    // Clock and reset
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    // Control
    input  wire logic                       paging_en_i,
    input  wire logic [pmf_pkg::ADDR_W-1:0] pdbr_i,
    input  wire logic [pmf_pkg::ADDR_W-1:0] lin_addr_i,
    // Results
    output logic      [pmf_pkg::ADDR_W-1:0] phys_addr_o,
    output logic      [pmf_pkg::IDX_W-1:0]  dir_idx_o,
    output logic      [pmf_pkg::IDX_W-1:0]  tbl_idx_o,
    output logic      [pmf_pkg::OFFS_W-1:0] page_offs_o,
    output logic      [pmf_pkg::ADDR_W-1:0] dir_entry_addr_o,
    output logic                            walk_req_o
);
    wire [IDX_W-1:0]  dir_w  = lin_addr_i[DIR_IDX_LO +: IDX_W];
    wire [IDX_W-1:0]  tbl_w  = lin_addr_i[TBL_IDX_LO +: IDX_W];
    wire [OFFS_W-1:0] offs_w = lin_addr_i[OFFS_W-1:0];
    wire [ADDR_W-1:0] pde_w  = (pdbr_i & PDBR_MASK) | {20'h0_0000, dir_w, 2'h0};
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phys_addr_o      <= '0;
            dir_idx_o        <= '0;
            tbl_idx_o        <= '0;
            page_offs_o      <= '0;
            dir_entry_addr_o <= '0;
            walk_req_o       <= 1'b0;
        end else begin
            phys_addr_o      <= paging_en_i ? '0 : lin_addr_i;
            dir_idx_o        <= paging_en_i ? dir_w : '0;
            tbl_idx_o        <= paging_en_i ? tbl_w : '0;
            page_offs_o      <= paging_en_i ? offs_w : '0;
            dir_entry_addr_o <= paging_en_i ? pde_w : '0;
            walk_req_o       <= paging_en_i;
        end
    end
    property p_flat;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !paging_en_i |=> phys_addr_o == $past(lin_addr_i) && !walk_req_o;
    endproperty
    a_flat: assert property (p_flat) else $error("flat address not passed through");
    property p_split;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        paging_en_i |=> {dir_idx_o, tbl_idx_o, page_offs_o} == $past(lin_addr_i);
    endproperty
    a_split: assert property (p_split) else $error("paged address split wrong");
    property p_pde;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        paging_en_i |=> dir_entry_addr_o[ADDR_W-1:TBL_IDX_LO] == $past(pdbr_i[ADDR_W-1:TBL_IDX_LO]);
    endproperty
    a_pde: assert property (p_pde) else $error("directory base not used");
endmodule : pmf_xlate

// file: design/pmf_core.sv
// Notes on behaviour
// - Paging off: physical address equals linear address.
// - Paging on with protection enabled: linear address splits into directory, table and offset.
// - Directory base comes from the page directory base register.
// - Reset leaves the core in real-address mode.
// - Protection enable chooses real or protected mode.
// - In protected mode the virtual-8086 flag picks the submode.
// - Management interrupt in any ordinary mode enters management state.
// - Active-low pin requests management; entry saves context, switches address space.
// - Resume restores saved state and the exact earlier mode.
// - Single-step flag, bit 8, raises a debug trap after each instruction outside management state.
// - Step set by pop or return traps only after the next instruction.
// - Maskable interrupts accepted only while enable flag bit 9 is set.
// - Enable flag never gates exceptions or non-maskable interrupts.
// - Enable-flag changes gated by privilege level and I/O field; extensions bit not used.
// - I/O field in bits 12-13; I/O allowed when privilege not above it.
// - I/O field changes only via pop or return at privilege level 0, or by resume.
// - In virtual-8086, enable changes need I/O field 3, with extensions on or off.
// - Virtual-8086 select flag sits at bit 17.
`timescale 1ns/10ps
module pmf_core
    import pmf_pkg::*;
(
    // Clock and reset
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_n_i,
    // Control register state
    input  wire logic                       protection_enable_flag_i,
    input  wire logic                       paging_enable_i,
    input  wire logic                       virtual_mode_extensions_bit_i,
    input  wire logic                       pdbr_wr_i,
    input  wire logic [pmf_pkg::ADDR_W-1:0] pdbr_wdata_i,
    // Instruction retirement
    input  wire logic                       instr_done_i,
    input  wire pmf_pkg::pmf_op_t           instr_op_i,
    input  wire logic [pmf_pkg::FLAG_W-1:0] flags_wdata_i,
    input  wire logic [1:0]                 current_privilege_level_i,
    input  wire logic                       io_access_i,
    input  wire logic                       resume_from_mgmt_instr_i,
    // Interrupt sources
    input  wire logic                       mgmt_interrupt_pin_n_i,
    input  wire logic                       intr_req_i,
    input  wire logic                       nmi_req_i,
    input  wire logic                       exception_i,
    // Addressing
    input  wire logic [pmf_pkg::ADDR_W-1:0] lin_addr_i,
    output logic      [pmf_pkg::ADDR_W-1:0] phys_addr_o,
    output logic      [pmf_pkg::IDX_W-1:0]  dir_idx_o,
    output logic      [pmf_pkg::IDX_W-1:0]  tbl_idx_o,
    output logic      [pmf_pkg::OFFS_W-1:0] page_offs_o,
    output logic      [pmf_pkg::ADDR_W-1:0] dir_entry_addr_o,
    output logic                            walk_req_o,
    output logic      [pmf_pkg::ADDR_W-1:0] page_directory_base_register_o,
    // Status
    output logic      [pmf_pkg::FLAG_W-1:0] processor_flags_o,
    output pmf_pkg::pmf_mode_t              mode_o,
    output logic                            mgmt_space_o,
    output logic                            ctx_save_o,
    output logic                            ctx_restore_o,
    output logic                            debug_trap_o,
    output logic                            intr_ack_o,
    output logic                            nmi_ack_o,
    output logic                            exc_take_o,
    output logic                            io_fault_o,
    output logic                            io_grant_o
);
    // ****************************************
    // State
    // ****************************************
    logic [FLAG_W-1:0] flags_reg;
    logic [FLAG_W-1:0] flags_next;
    logic [FLAG_W-1:0] saved_flags_reg;
    pmf_mode_t         mode_reg;
    pmf_mode_t         mode_next;
    pmf_mode_t         saved_mode_reg;
    logic [ADDR_W-1:0] pdbr_reg;
    logic              step_arm_reg;
    logic              trap_reg;
    logic              io_fault_reg;
    logic              smi_s;
    logic              smi_s_d_reg;

    pmf_sync u_smi_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (mgmt_interrupt_pin_n_i),
        .sync_o    (smi_s)
    );

    pmf_xlate u_xlate (
        .ref_clk_i        (ref_clk_i),
        .rst_n_i          (rst_n_i),
        .paging_en_i      (paging_enable_i && protection_enable_flag_i),
        .pdbr_i           (pdbr_reg),
        .lin_addr_i       (lin_addr_i),
        .phys_addr_o      (phys_addr_o),
        .dir_idx_o        (dir_idx_o),
        .tbl_idx_o        (tbl_idx_o),
        .page_offs_o      (page_offs_o),
        .dir_entry_addr_o (dir_entry_addr_o),
        .walk_req_o       (walk_req_o)
    );

    // ****************************************
    // Decode
    // ****************************************
    wire        in_mgmt_w   = (mode_reg == PMF_MGMT);
    wire [1:0]  io_privilege_field_w      = flags_reg[IO_PRIVILEGE_FIELD_HI_B:IO_PRIVILEGE_FIELD_LO_B];
    wire [1:0]  cpl_w       = current_privilege_level_i;
    // Falling edge of the synchronised pin: one request per assertion
    wire        smi_evt_w   = smi_s_d_reg && !smi_s && !in_mgmt_w;
    wire        rsm_w       = resume_from_mgmt_instr_i && in_mgmt_w;
    wire        op_flags_pop_instr_w   = instr_done_i && (instr_op_i == PMF_OP_FLAGS_POP_INSTR);
    wire        op_interrupt_return_instr_w   = instr_done_i && (instr_op_i == PMF_OP_INTERRUPT_RETURN_INSTR);
    wire        op_task_w   = instr_done_i && (instr_op_i == PMF_OP_TASK);
    wire        op_cli_w    = instr_done_i && (instr_op_i == PMF_OP_CLI);
    wire        op_sti_w    = instr_done_i && (instr_op_i == PMF_OP_STI);
    wire        op_load_w   = op_flags_pop_instr_w || op_interrupt_return_instr_w || op_task_w;
    wire        is_v86_w    = (mode_reg == PMF_V86);
    wire        io_privilege_field_ok_w   = (cpl_w <= io_privilege_field_w);
    // Virtual-8086 compares against level 3; extensions bit not used
    wire        v86_if_ok_w = (io_privilege_field_w == 2'h3);
    wire        if_ok_w     = is_v86_w ? v86_if_ok_w : (!protection_enable_flag_i || io_privilege_field_ok_w);
    wire        io_privilege_field_wr_ok_w = (op_flags_pop_instr_w || op_interrupt_return_instr_w) && (cpl_w == 2'h0);
    wire        vm_wr_ok_w  = (op_interrupt_return_instr_w && cpl_w == 2'h0) || op_task_w;
    wire        step_load_w = (op_flags_pop_instr_w || op_interrupt_return_instr_w) && flags_wdata_i[SINGLE_STEP_B]
                              && !flags_reg[SINGLE_STEP_B];
    wire        v86_io_ok_w = virtual_mode_extensions_bit_i ? io_privilege_field_ok_w : io_privilege_field_ok_w;
    wire        io_ok_w     = !protection_enable_flag_i || (is_v86_w ? v86_io_ok_w : io_privilege_field_ok_w);

    // ****************************************
    // Flags update
    // ****************************************
    always_comb begin
        flags_next = flags_reg;
        if (op_load_w) begin
            // System bits other than the step flag keep their old value unless a gate below lets them change
            flags_next = (flags_reg & ~(FLAGS_WMASK & ~FLAGS_SYSMASK)) | (flags_wdata_i & FLAGS_WMASK & ~FLAGS_SYSMASK);
            flags_next[SINGLE_STEP_B] = flags_wdata_i[SINGLE_STEP_B];
            if (if_ok_w)
                flags_next[INT_ENABLE_B] = flags_wdata_i[INT_ENABLE_B];
            if (io_privilege_field_wr_ok_w)
                flags_next[IO_PRIVILEGE_FIELD_HI_B:IO_PRIVILEGE_FIELD_LO_B] = flags_wdata_i[IO_PRIVILEGE_FIELD_HI_B:IO_PRIVILEGE_FIELD_LO_B];
            if (vm_wr_ok_w)
                flags_next[V86_SELECT_B] = flags_wdata_i[V86_SELECT_B];
        end else if (op_cli_w && if_ok_w) begin
            flags_next[INT_ENABLE_B] = 1'b0;
        end else if (op_sti_w && if_ok_w) begin
            flags_next[INT_ENABLE_B] = 1'b1;
        end
        if (rsm_w)
            flags_next = saved_flags_reg;
        flags_next = flags_next | FLAGS_FIXED1;
    end

    // ****************************************
    // Mode selection
    // ****************************************
    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            PMF_REAL, PMF_PROT, PMF_V86: begin
                if (smi_evt_w)
                    mode_next = PMF_MGMT;
                else if (!protection_enable_flag_i)
                    mode_next = PMF_REAL;
                else if (flags_next[V86_SELECT_B])
                    mode_next = PMF_V86;
                else
                    mode_next = PMF_PROT;
            end
            PMF_MGMT: begin
                if (rsm_w)
                    mode_next = saved_mode_reg;
            end
            default: mode_next = PMF_REAL;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg       <= FLAGS_RESET;
            mode_reg        <= PMF_REAL;
            saved_flags_reg <= FLAGS_RESET;
            saved_mode_reg  <= PMF_REAL;
            pdbr_reg        <= PDBR_RESET;
            smi_s_d_reg     <= 1'b1;
        end else begin
            flags_reg   <= flags_next;
            mode_reg    <= mode_next;
            smi_s_d_reg <= smi_s;
            if (pdbr_wr_i)
                pdbr_reg <= pdbr_wdata_i & PDBR_MASK;
            if (smi_evt_w) begin
                saved_flags_reg <= flags_reg;
                saved_mode_reg  <= mode_reg;
            end
        end
    end

    // Stepping: old flag gates the trap, so the pop or return that sets it never traps
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            step_arm_reg <= 1'b0;
            trap_reg     <= 1'b0;
            io_fault_reg <= 1'b0;
        end else begin
            if (step_load_w)
                step_arm_reg <= 1'b1;
            else if (instr_done_i || !flags_reg[SINGLE_STEP_B])
                step_arm_reg <= 1'b0;
            trap_reg     <= instr_done_i && flags_reg[SINGLE_STEP_B]
                            && !step_load_w && !in_mgmt_w;
            io_fault_reg <= io_access_i && !io_ok_w;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign processor_flags_o              = flags_reg;
    assign mode_o                         = mode_reg;
    assign page_directory_base_register_o = pdbr_reg;
    assign mgmt_space_o                   = in_mgmt_w;
    assign ctx_save_o                     = smi_evt_w;
    assign ctx_restore_o                  = rsm_w;
    assign debug_trap_o                   = trap_reg;
    assign io_fault_o                     = io_fault_reg;
    assign io_grant_o                     = io_access_i && io_ok_w;
    assign intr_ack_o                     = intr_req_i && flags_reg[INT_ENABLE_B] && !in_mgmt_w;
    assign nmi_ack_o                      = nmi_req_i;
    assign exc_take_o                     = exception_i;

    // ****************************************
    // Checks
    // ****************************************
    property p_reset_real;
        @(posedge ref_clk_i) $rose(rst_n_i) |-> mode_o == PMF_REAL;
    endproperty
    a_reset_real: assert property (p_reset_real) else $error("not real mode after reset");
    property p_pe_clear;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !protection_enable_flag_i && !smi_evt_w && !in_mgmt_w |=> mode_o == PMF_REAL;
    endproperty
    a_pe_clear: assert property (p_pe_clear) else $error("real mode not chosen");
    property p_v86_sel;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        protection_enable_flag_i && !in_mgmt_w && !smi_evt_w |=>
            (mode_o == PMF_V86) == processor_flags_o[17];
    endproperty
    a_v86_sel: assert property (p_v86_sel) else $error("virtual-8086 select wrong");
    property p_smi_enter;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        smi_evt_w |=> mode_o == PMF_MGMT && mgmt_space_o;
    endproperty
    a_smi_enter: assert property (p_smi_enter) else $error("management entry missed");
    property p_pin_to_entry;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !in_mgmt_w && $fell(smi_s) |=> in_mgmt_w;
    endproperty
    a_pin_to_entry: assert property (p_pin_to_entry) else $error("pin request not taken");
    property p_resume;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        rsm_w |=> mode_o == $past(saved_mode_reg) && processor_flags_o == $past(saved_flags_reg);
    endproperty
    a_resume: assert property (p_resume) else $error("resume mode wrong");
    property p_no_step;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !flags_reg[8] |=> !debug_trap_o;
    endproperty
    a_no_step: assert property (p_no_step) else $error("trap with step clear");
    property p_step_delay;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        step_load_w |=> !debug_trap_o;
    endproperty
    a_step_delay: assert property (p_step_delay) else $error("early step trap");
    property p_step_first;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        step_arm_reg && flags_reg[SINGLE_STEP_B] && instr_done_i && !in_mgmt_w |=> debug_trap_o;
    endproperty
    a_step_first: assert property (p_step_first) else $error("first step trap missed");
    property p_if_mask;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        intr_ack_o |-> flags_reg[9];
    endproperty
    a_if_mask: assert property (p_if_mask) else $error("interrupt taken while masked");
    property p_nmi;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        nmi_req_i |-> nmi_ack_o;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi gated");
    property p_io_privilege_field_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !io_privilege_field_wr_ok_w && !rsm_w |=> $stable(processor_flags_o[13:12]);
    endproperty
    a_io_privilege_field_hold: assert property (p_io_privilege_field_hold) else $error("io field changed illegally");
    property p_io_fault;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        io_access_i && protection_enable_flag_i && !is_v86_w && cpl_w > io_privilege_field_w |=> io_fault_o;
    endproperty
    a_io_fault: assert property (p_io_fault) else $error("io access not refused");
    property p_if_gate;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (op_cli_w || op_sti_w) && !if_ok_w && !rsm_w |=> $stable(processor_flags_o[9]);
    endproperty
    a_if_gate: assert property (p_if_gate) else $error("enable flag changed illegally");
    c_smi_rsm: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) smi_evt_w ##[1:50] rsm_w);
    c_v86: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) mode_o == PMF_V86);
    c_trap: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) debug_trap_o);
    c_iofault: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) io_fault_o);
endmodule : pmf_core

// file: tb/pmf_mgmt_src.sv
`timescale 1ns/10ps
// ****************************************
// Management interrupt source
// ****************************************
module pmf_mgmt_src (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // Request and pin
    input  wire logic fire_i,
    output logic      mgmt_interrupt_pin_n_o
);
    logic [2:0] hold_reg;
    // Held low several cycles so the two-stage sync cannot miss it
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) hold_reg <= 3'h0;
        else if (fire_i) hold_reg <= 3'h4;
        else if (hold_reg != 3'h0) hold_reg <= hold_reg - 3'h1;
    end
    assign mgmt_interrupt_pin_n_o = (hold_reg == 3'h0);
endmodule : pmf_mgmt_src

// file: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    import pmf_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        ref_clk_i, rst_n_i, pe, pg, virtual_mode_extensions_bit, pdbr_wr, done, io_acc, resume_from_mgmt_instr, fire, intr, nmi, exc, pin_n;
    logic        mspace, csave, crest, trap, iack, nack, etake, iofault, iogrant, walk;
    logic [31:0] pdbr_wd, fl_wd, lin, phys, dire, pdbr_q, flags;
    logic [9:0]  dir_idx, tbl_idx;
    logic [11:0] offs;
    logic [1:0]  current_privilege_level;
    pmf_op_t     op;
    pmf_mode_t   mode;
    int          err_total, n_checks, n_trap, n_fault, n_save, cyc, base;

    pmf_core u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .protection_enable_flag_i(pe),
        .paging_enable_i(pg), .virtual_mode_extensions_bit_i(virtual_mode_extensions_bit), .pdbr_wr_i(pdbr_wr),
        .pdbr_wdata_i(pdbr_wd), .instr_done_i(done), .instr_op_i(op), .flags_wdata_i(fl_wd),
        .current_privilege_level_i(current_privilege_level), .io_access_i(io_acc), .resume_from_mgmt_instr_i(resume_from_mgmt_instr),
        .mgmt_interrupt_pin_n_i(pin_n), .intr_req_i(intr), .nmi_req_i(nmi), .exception_i(exc),
        .lin_addr_i(lin), .phys_addr_o(phys), .dir_idx_o(dir_idx), .tbl_idx_o(tbl_idx),
        .page_offs_o(offs), .dir_entry_addr_o(dire), .walk_req_o(walk),
        .page_directory_base_register_o(pdbr_q), .processor_flags_o(flags), .mode_o(mode),
        .mgmt_space_o(mspace), .ctx_save_o(csave), .ctx_restore_o(crest), .debug_trap_o(trap),
        .intr_ack_o(iack), .nmi_ack_o(nack), .exc_take_o(etake), .io_fault_o(iofault),
        .io_grant_o(iogrant));
    pmf_mgmt_src u_src (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .fire_i(fire),
        .mgmt_interrupt_pin_n_o(pin_n));

    always #2.5 ref_clk_i = ~ref_clk_i;
    // Pulses are counted so their exact cycle need not be guessed
    always @(posedge ref_clk_i) begin
        cyc++;
        if (trap === 1'b1) n_trap++;
        if (iofault === 1'b1) n_fault++;
        if (csave === 1'b1) n_save++;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end

    task automatic tick(int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : tick
    task automatic retire(pmf_op_t o, logic [31:0] d, logic [1:0] p);
        @(negedge ref_clk_i);
        op = o; fl_wd = d; current_privilege_level = p; done = 1'b1;
        @(negedge ref_clk_i);
        done = 1'b0; op = PMF_OP_NONE;
    endtask : retire
    task automatic t_xlate();
        `CHK("mode", PMF_REAL, mode)
        `CHK("flags", 32'h0000_0002, flags)
        lin = 32'h1234_5678; tick(2);
        `CHK("phys", 32'h1234_5678, phys)
        pdbr_wd = 32'hABCD_E123; pdbr_wr = 1'b1; tick(1); pdbr_wr = 1'b0; tick(1);
        `CHK("pdbr", 32'hABCD_E000, pdbr_q)
        pe = 1'b1; pg = 1'b1; tick(2);
        `CHK("dir", 10'h048, dir_idx)
        `CHK("tbl", 10'h345, tbl_idx)
        `CHK("offs", 12'h678, offs)
        `CHK("walk", 1'b1, walk)
        `CHK("pde", 32'hABCD_E120, dire)
        `CHK("mode", PMF_PROT, mode)
        pg = 1'b0;
    endtask : t_xlate
    task automatic t_v86();
        retire(PMF_OP_INTERRUPT_RETURN_INSTR, 32'h0002_0002, 2'h0); tick(1);
        `CHK("mode", PMF_V86, mode)
        `CHK("vm", 1'b1, flags[17])
        retire(PMF_OP_INTERRUPT_RETURN_INSTR, 32'h0000_0002, 2'h0); tick(1);
        `CHK("mode", PMF_PROT, mode)
        retire(PMF_OP_INTERRUPT_RETURN_INSTR, 32'h0002_0002, 2'h3); tick(1);
        `CHK("vm", 1'b0, flags[17])
        retire(PMF_OP_TASK, 32'h0002_0002, 2'h3); tick(1);
        `CHK("mode", PMF_V86, mode)
        virtual_mode_extensions_bit = 1'b1;
        retire(PMF_OP_STI, 32'h0000_0002, 2'h3);
        `CHK("if", 1'b0, flags[9])
        retire(PMF_OP_FLAGS_POP_INSTR, 32'h0000_3002, 2'h0);
        retire(PMF_OP_STI, 32'h0000_0002, 2'h3);
        `CHK("if", 1'b1, flags[9])
        `CHK("mode", PMF_V86, mode)
        virtual_mode_extensions_bit = 1'b0;
        retire(PMF_OP_TASK, 32'h0000_0002, 2'h3); tick(1);
        `CHK("mode", PMF_PROT, mode)
        retire(PMF_OP_FLAGS_POP_INSTR, 32'h0000_0002, 2'h0);
        `CHK("io_privilege_field", 2'h0, flags[13:12])
    endtask : t_v86
    task automatic t_mgmt();
        fire = 1'b1; tick(1); fire = 1'b0; tick(5);
        `CHK("mode", PMF_MGMT, mode)
        `CHK("space", 1'b1, mspace)
        `CHK("save", 1, n_save)
        resume_from_mgmt_instr = 1'b1; #1;
        `CHK("restore", 1'b1, crest)
        tick(1); resume_from_mgmt_instr = 1'b0; tick(1);
        `CHK("mode", PMF_PROT, mode)
    endtask : t_mgmt
    task automatic t_step();
        base = n_trap;
        retire(PMF_OP_FLAGS_POP_INSTR, 32'h0000_0102, 2'h0); tick(1);
        `CHK("trap", base, n_trap)
        retire(PMF_OP_OTHER, 32'h0000_0102, 2'h0); tick(2);
        `CHK("trap", base + 1, n_trap)
        retire(PMF_OP_FLAGS_POP_INSTR, 32'h0000_0002, 2'h0); tick(2); base = n_trap;
        retire(PMF_OP_OTHER, 32'h0000_0002, 2'h0); tick(2);
        `CHK("trap", base, n_trap)
    endtask : t_step
    task automatic t_intr();
        retire(PMF_OP_STI, 32'h0000_0002, 2'h0); intr = 1'b1; #1;
        `CHK("iack", 1'b1, iack)
        retire(PMF_OP_CLI, 32'h0000_0002, 2'h0); nmi = 1'b1; exc = 1'b1; #1;
        `CHK("iack", 1'b0, iack)
        `CHK("nack", 1'b1, nack)
        `CHK("exc", 1'b1, etake)
        retire(PMF_OP_STI, 32'h0000_0002, 2'h3);
        `CHK("if", 1'b0, flags[9])
        intr = 1'b0; nmi = 1'b0; exc = 1'b0;
    endtask : t_intr
    task automatic t_io_privilege_field();
        retire(PMF_OP_FLAGS_POP_INSTR, 32'h0000_2002, 2'h0);
        `CHK("io_privilege_field", 2'h2, flags[13:12])
        retire(PMF_OP_FLAGS_POP_INSTR, 32'h0000_3002, 2'h1);
        `CHK("io_privilege_field", 2'h2, flags[13:12])
        current_privilege_level = 2'h2; io_acc = 1'b1; #1;
        `CHK("grant", 1'b1, iogrant)
        tick(1); base = n_fault; current_privilege_level = 2'h3; #1;
        `CHK("grant", 1'b0, iogrant)
        tick(1); io_acc = 1'b0; tick(2);
        `CHK("fault", base + 1, n_fault)
    endtask : t_io_privilege_field
    task automatic close_out();
        if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    initial begin
        {ref_clk_i, rst_n_i, pe, pg, virtual_mode_extensions_bit, pdbr_wr, done, io_acc, resume_from_mgmt_instr, fire, intr, nmi, exc} = '0;
        {pdbr_wd, fl_wd, lin, current_privilege_level} = '0;
        op = PMF_OP_NONE;
        tick(20); rst_n_i = 1'b1; tick(1);
        t_xlate(); t_v86(); t_mgmt(); t_step(); t_intr(); t_io_privilege_field();
        close_out();
    end
endmodule : tb_top
